// file: verilog/bus_idle_cs_extension.sv
// Purpose: Idle-cycle insertion and chip-select stretch for four areas
// Assumes: Single 10 MHz clock, rst_i is the power-on reset
// Notes: Access is one strobe cycle; wait states live elsewhere
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "bus_idle_cs_regs.svh"

module bus_idle_cs_extension #(
    parameter int ADDR_W = 4
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic manual_rst_i,
    input wire logic standby_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic req_valid_i,
    input wire bus_idle_cs_pkg::access_req_s req_i,
    output logic req_ready_o,
    output logic [3:0] area_chip_select_n_o,
    output logic read_strobe_n_o,
    output logic write_strobe_n_o,
    output logic access_done_o,
    output logic idle_insert_o
);

    // ==========================================
    // Timing register
    logic [15:0] bus_idle_and_select_timing_q;
    logic [15:0] rdata_q;
    logic hit_wr;
    logic hit_rd;

    assign hit_wr = reg_wr_i && (reg_addr_i == `TIMING_OFFSET);
    assign hit_rd = reg_rd_i && (reg_addr_i == `TIMING_OFFSET);

    // Only power-on reset loads it; manual reset and standby never reach it
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bus_idle_and_select_timing_q <= `TIMING_RESET;
        end else if (hit_wr) begin
            bus_idle_and_select_timing_q <= reg_wdata_i;
        end
    end

    // Unmapped reads answer zero
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_q <= 16'h0000;
        end else if (hit_rd) begin
            rdata_q <= bus_idle_and_select_timing_q;
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata_o = rdata_q;

    // ==========================================
    // Per-area field split
    logic [1:0] turnaround_idle [`AREA_COUNT];
    logic [`AREA_COUNT-1:0] back_to_back_idle;
    logic [`AREA_COUNT-1:0] select_stretch;

    for (genvar a = 0; a < `AREA_COUNT; a++) begin : g_area
        assign turnaround_idle[a] =
            bus_idle_and_select_timing_q[`TURNAROUND_LSB + 2*a +: `TURNAROUND_BITS];
        assign back_to_back_idle[a] = bus_idle_and_select_timing_q[`BACK_TO_BACK_LSB + a];
        assign select_stretch[a] = bus_idle_and_select_timing_q[`STRETCH_LSB + a];
    end

    // ==========================================
    // Access sequencer state
    bus_idle_cs_pkg::seq_state_e state_q;
    bus_idle_cs_pkg::seq_state_e state_d;
    logic [1:0] area_q;
    logic write_q;
    logic [1:0] gap_cnt_q;
    logic last_valid_q;
    logic [1:0] last_area_q;
    logic last_write_q;
    logic [1:0] elapsed_q;

    logic halt;
    logic accept;
    logic [1:0] elapsed;
    logic [1:0] need;
    logic [1:0] gap;
    logic [1:0] iw_last;
    logic [1:0] cw_last;
    logic same_area;
    logic stretch_cur;

    assign halt = manual_rst_i || standby_i;
    assign stretch_cur = select_stretch[area_q];

    // Next request may overlap the last cycle of an access so cw=0 runs truly back to back
    always_comb begin
        req_ready_o = 1'b0;
        if (!halt) begin
            unique case (state_q)
                bus_idle_cs_pkg::ST_IDLE: req_ready_o = 1'b1;
                bus_idle_cs_pkg::ST_XFER: req_ready_o = !stretch_cur;
                bus_idle_cs_pkg::ST_TRAIL: req_ready_o = 1'b1;
                bus_idle_cs_pkg::ST_GAP: req_ready_o = 1'b0;
                bus_idle_cs_pkg::ST_LEAD: req_ready_o = 1'b0;
            endcase
        end
    end

    assign accept = req_valid_i && req_ready_o;

    // ==========================================
    // Idle count for the incoming access
    // A request taken in the strobe cycle follows the access now on the bus,
    // whose history is only written at the end of that cycle
    logic prev_valid;
    logic [1:0] prev_area;
    logic prev_write;

    assign prev_valid = last_valid_q || (state_q == bus_idle_cs_pkg::ST_XFER);
    assign prev_area = (state_q == bus_idle_cs_pkg::ST_XFER) ? area_q : last_area_q;
    assign prev_write = (state_q == bus_idle_cs_pkg::ST_XFER) ? write_q : last_write_q;

    assign iw_last = turnaround_idle[prev_area];
    assign cw_last = {1'b0, back_to_back_idle[prev_area]};
    assign same_area = (req_i.area == prev_area);
    assign elapsed = (state_q == bus_idle_cs_pkg::ST_IDLE) ? elapsed_q : 2'h0;

    always_comb begin
        need = 2'h0;
        if (prev_valid) begin
            if (same_area) begin
                if (!prev_write && req_i.write) begin
                    need = (iw_last > cw_last) ? iw_last : cw_last;
                end else begin
                    need = cw_last;
                end
            end else if (!prev_write) begin
                need = iw_last;
            end
        end
    end

    // Idle time already spent on the bus counts toward the gap
    assign gap = (need > elapsed) ? (need - elapsed) : 2'h0;

    // ==========================================
    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            bus_idle_cs_pkg::ST_IDLE: begin
                state_d = bus_idle_cs_pkg::ST_IDLE;
            end
            bus_idle_cs_pkg::ST_GAP: begin
                if (gap_cnt_q == 2'h0) begin
                    state_d = stretch_cur ? bus_idle_cs_pkg::ST_LEAD : bus_idle_cs_pkg::ST_XFER;
                end
            end
            bus_idle_cs_pkg::ST_LEAD: begin
                state_d = bus_idle_cs_pkg::ST_XFER;
            end
            bus_idle_cs_pkg::ST_XFER: begin
                state_d = stretch_cur ? bus_idle_cs_pkg::ST_TRAIL : bus_idle_cs_pkg::ST_IDLE;
            end
            bus_idle_cs_pkg::ST_TRAIL: begin
                state_d = bus_idle_cs_pkg::ST_IDLE;
            end
        endcase
        if (accept) begin
            if (gap != 2'h0) begin
                state_d = bus_idle_cs_pkg::ST_GAP;
            end else if (select_stretch[req_i.area]) begin
                state_d = bus_idle_cs_pkg::ST_LEAD;
            end else begin
                state_d = bus_idle_cs_pkg::ST_XFER;
            end
        end
    end

    // Manual reset aborts the bus; standby lets the access in flight finish and takes no new ones; both keep the timing register
    always_ff @(posedge mclk_i) begin
        if (rst_i || manual_rst_i) begin
            state_q <= bus_idle_cs_pkg::ST_IDLE;
        end else if (standby_i && state_q == bus_idle_cs_pkg::ST_IDLE) begin
            state_q <= bus_idle_cs_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            area_q <= 2'h0;
            write_q <= 1'b0;
        end else if (accept) begin
            area_q <= req_i.area;
            write_q <= req_i.write;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            gap_cnt_q <= 2'h0;
        end else if (accept) begin
            gap_cnt_q <= (gap != 2'h0) ? gap - 2'h1 : 2'h0;
        end else if (state_q == bus_idle_cs_pkg::ST_GAP && gap_cnt_q != 2'h0) begin
            gap_cnt_q <= gap_cnt_q - 2'h1;
        end
    end

    // ==========================================
    // History of the previous access
    always_ff @(posedge mclk_i) begin
        if (rst_i || manual_rst_i) begin
            last_valid_q <= 1'b0;
            last_area_q <= 2'h0;
            last_write_q <= 1'b0;
        end else if (state_q == bus_idle_cs_pkg::ST_XFER) begin
            last_valid_q <= 1'b1;
            last_area_q <= area_q;
            last_write_q <= write_q;
        end
    end

    // Idle cycles since the previous access ended, saturating
    always_ff @(posedge mclk_i) begin
        if (rst_i || manual_rst_i) begin
            elapsed_q <= `IDLE_SAT;
        end else if (state_q != bus_idle_cs_pkg::ST_IDLE) begin
            elapsed_q <= 2'h1;
        end else if (elapsed_q != `IDLE_SAT) begin
            elapsed_q <= elapsed_q + 2'h1;
        end
    end

    // ==========================================
    // Pin decode, idle and gap cycles keep everything negated
    logic select_on;

    assign select_on = (state_q == bus_idle_cs_pkg::ST_LEAD) ||
                       (state_q == bus_idle_cs_pkg::ST_XFER) ||
                       (state_q == bus_idle_cs_pkg::ST_TRAIL);

    for (genvar c = 0; c < `AREA_COUNT; c++) begin : g_cs
        assign area_chip_select_n_o[c] = !(select_on && area_q == 2'(c));
    end

    assign read_strobe_n_o = !(state_q == bus_idle_cs_pkg::ST_XFER && !write_q);
    assign write_strobe_n_o = !(state_q == bus_idle_cs_pkg::ST_XFER && write_q);
    assign access_done_o = (state_q == bus_idle_cs_pkg::ST_XFER);
    assign idle_insert_o = (state_q == bus_idle_cs_pkg::ST_GAP);

    // ==========================================
    // Checks
    reg_reset_a: assert property (
        @(posedge mclk_i) $fell(rst_i) |-> bus_idle_and_select_timing_q == `TIMING_RESET)
        else $error("timing register not all ones after power-on reset");

    reg_write_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        hit_wr |=> bus_idle_and_select_timing_q == $past(reg_wdata_i))
        else $error("timing register write lost");

    reg_readback_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        hit_rd && !$past(hit_wr) |=> reg_rdata_o == $past(bus_idle_and_select_timing_q))
        else $error("timing register read data wrong");

    reg_keep_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (manual_rst_i || standby_i) && !hit_wr |=> $stable(bus_idle_and_select_timing_q))
        else $error("timing register changed by manual reset or standby");

    gap_quiet_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        idle_insert_o |-> area_chip_select_n_o == 4'hf && read_strobe_n_o && write_strobe_n_o && !req_ready_o)
        else $error("bus active during inserted idle");

    gap_three_a: assert property (
        @(posedge mclk_i) disable iff (rst_i || manual_rst_i)
        accept && gap == 2'h3 |=> idle_insert_o [*3] ##1 !idle_insert_o)
        else $error("three idle cycles not inserted");

    gap_one_a: assert property (
        @(posedge mclk_i) disable iff (rst_i || manual_rst_i)
        accept && gap == 2'h1 |=> idle_insert_o ##1 !idle_insert_o)
        else $error("one idle cycle not inserted");

    area_switch_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        accept && prev_valid && !prev_write && !same_area && elapsed == 2'h0
        |-> gap == bus_idle_and_select_timing_q[`TURNAROUND_LSB + 2*prev_area +: 2])
        else $error("turnaround idle not taken from previous area");

    write_after_read_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        accept && prev_valid && !prev_write && same_area && req_i.write && elapsed == 2'h0
        |-> gap >= iw_last && gap >= cw_last && (gap == iw_last || gap == cw_last))
        else $error("write after read gap is not the larger count");

    stretch_lead_a: assert property (
        @(posedge mclk_i) disable iff (rst_i || manual_rst_i)
        state_q == bus_idle_cs_pkg::ST_LEAD |-> area_chip_select_n_o != 4'hf && read_strobe_n_o
        ##1 access_done_o ##1 (!stretch_cur || (area_chip_select_n_o != 4'hf && read_strobe_n_o
        && write_strobe_n_o)))
        else $error("select stretch window wrong");

    gap_two_a: assert property (
        @(posedge mclk_i) disable iff (rst_i || manual_rst_i)
        accept && gap == 2'h2 |=> idle_insert_o [*2] ##1 !idle_insert_o)
        else $error("two idle cycles not inserted");

    same_area_gap_a: assert property (
        @(posedge mclk_i) disable iff (rst_i || manual_rst_i)
        accept && prev_valid && same_area && !(!prev_write && req_i.write) && elapsed == 2'h0
        && back_to_back_idle[prev_area] |=> area_chip_select_n_o == 4'hf && idle_insert_o)
        else $error("select not negated between same-area accesses");

    strobe_select_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !read_strobe_n_o || !write_strobe_n_o |-> $onehot(~area_chip_select_n_o))
        else $error("strobe outside a single chip select");

    one_select_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        $onehot0(~area_chip_select_n_o))
        else $error("more than one chip select active");

    halt_ready_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        manual_rst_i || standby_i |-> !req_ready_o)
        else $error("request taken during manual reset or standby");

endmodule
`default_nettype wire

// file: verilog/bus_idle_cs_regs.svh
// Purpose: Register map and field layout of the idle/select timing block
// Assumes: One 16-bit register on a plain strobe port
// Notes: Definitions only
`ifndef BUS_IDLE_CS_REGS_SVH
`define BUS_IDLE_CS_REGS_SVH

// ==========================================
// Register map
`define TIMING_OFFSET 4'h0
`define TIMING_RESET 16'hffff
`define TIMING_WIDTH 16

// ==========================================
// Field positions, per area
`define TURNAROUND_LSB 8
`define TURNAROUND_BITS 2
`define BACK_TO_BACK_LSB 4
`define STRETCH_LSB 0

// ==========================================
// Counts
`define IDLE_SAT 2'h3
`define AREA_COUNT 4

`endif

// file: verilog/bus_idle_cs_pkg.sv
// Purpose: Types shared by the idle/select timing block
// Assumes: Four chip-select areas
// Notes: Sequencer states are one-hot
package bus_idle_cs_pkg;

    // ==========================================
    // Sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_GAP = 5'h02,
        ST_LEAD = 5'h04,
        ST_XFER = 5'h08,
        ST_TRAIL = 5'h10
    } seq_state_e;

    // ==========================================
    // External access request
    typedef struct packed {
        logic [1:0] area;
        logic write;
    } access_req_s;

endpackage

// file: tb/area_device_model.sv
// Purpose: Devices on the four areas, watching selects and strobes
// Assumes: Active-low selects and strobes, one clock
// Notes: Reports idles between strobe cycles and select lead/trail
`timescale 1ns/100ps
`default_nettype none
module area_device_model (
    input wire logic mclk_i,
    input wire logic [3:0] sel_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    output logic [7:0] xfer_o,
    output logic [7:0] gap_o,
    output logic lead_o,
    output logic trail_o,
    output logic [7:0] err_o
);
    // ==========================================
    // Observation
    logic strobe;
    logic [3:0] prev_q;
    logic [3:0] mask_q;
    logic pend_q;
    logic [7:0] cnt_q;
    assign strobe = ~rd_n_i | ~wr_n_i;
    initial begin
        {xfer_o, gap_o, lead_o, trail_o, err_o, prev_q, mask_q, pend_q, cnt_q} = '0;
    end
    always @(posedge mclk_i) begin
        prev_q <= sel_n_i;
        pend_q <= strobe;
        cnt_q <= strobe ? 8'h00 : cnt_q + 8'h01;
        if (pend_q) begin
            trail_o <= |(mask_q & ~sel_n_i);
        end
        if (strobe) begin
            xfer_o <= xfer_o + 8'h01;
            gap_o <= cnt_q;
            mask_q <= ~sel_n_i;
            lead_o <= |(~sel_n_i & ~prev_q);
            // A strobe under no select, or two, would hit the wrong device
            if (!$onehot(~sel_n_i) || (!rd_n_i && !wr_n_i)) begin
                err_o <= err_o + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/bus_idle_cs_extension_tb.sv
// Purpose: Self-checking bench for the idle/select timing block
// Assumes: Register at 4'h0, no wait states
// Notes: Manual reset before each pair clears access history
`timescale 1ns/100ps
`default_nettype none
module bus_idle_cs_extension_tb;
    logic mclk_i, rst_i, manual_rst_i, standby_i, reg_wr_i, reg_rd_i, req_valid_i;
    logic [3:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, rd_q;
    bus_idle_cs_pkg::access_req_s req_i;
    logic req_ready_o, read_strobe_n_o, write_strobe_n_o, access_done_o, idle_insert_o, lead, trail;
    logic [3:0] area_chip_select_n_o;
    logic [7:0] xfer, gap, err, n_done;
    int n_fail = 0;
    int checks = 0;
    bus_idle_cs_extension uut (.mclk_i(mclk_i), .rst_i(rst_i), .manual_rst_i(manual_rst_i),
        .standby_i(standby_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .req_valid_i(req_valid_i), .req_i(req_i),
        .req_ready_o(req_ready_o), .area_chip_select_n_o(area_chip_select_n_o),
        .read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
        .access_done_o(access_done_o), .idle_insert_o(idle_insert_o));
    area_device_model dev (.mclk_i(mclk_i), .sel_n_i(area_chip_select_n_o), .rd_n_i(read_strobe_n_o),
        .wr_n_i(write_strobe_n_o), .xfer_o(xfer), .gap_o(gap), .lead_o(lead), .trail_o(trail), .err_o(err));
    always #50 mclk_i = ~mclk_i;

    // ==========================================
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic timed_out();
        n_fail++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        stop_test();
    endtask
    task automatic reg_w(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic reg_r(input logic [3:0] a);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        @(negedge mclk_i);
        rd_q = reg_rdata_o;
    endtask
    task automatic send(input logic [1:0] a, input logic w);
        int i;
        req_valid_i <= 1'b1;
        req_i <= {a, w};
        for (i = 0; i < 20; i++) begin
            @(negedge mclk_i);
            if (req_ready_o === 1'b1) break;
        end
        if (i == 20) timed_out();
        @(posedge mclk_i);
    endtask
    // Two back-to-back accesses, or one when two is low
    task automatic run(input logic [1:0] a1, input logic w1, input logic [1:0] a2, input logic w2,
        input logic two);
        logic [7:0] base;
        int i;
        @(posedge mclk_i);
        manual_rst_i <= 1'b1;
        @(posedge mclk_i);
        manual_rst_i <= 1'b0;
        base = xfer;
        send(a1, w1);
        if (two) send(a2, w2);
        req_valid_i <= 1'b0;
        for (i = 0; i < 20; i++) begin
            @(negedge mclk_i);
            if (xfer === base + {7'h00, two} + 8'h01) break;
        end
        if (i == 20) timed_out();
        repeat (2) @(negedge mclk_i);
    endtask

    // ==========================================
    // Watchers
    always @(posedge mclk_i) begin
        if (access_done_o === 1'b1) n_done <= n_done + 8'h01;
        if (idle_insert_o === 1'b1) begin
            check({10'h000, area_chip_select_n_o, read_strobe_n_o, write_strobe_n_o}, 16'h003f);
        end
    end

    // ==========================================
    // Sequence
    initial begin
        {mclk_i, manual_rst_i, standby_i, reg_wr_i, reg_rd_i, req_valid_i} = '0;
        {reg_addr_i, reg_wdata_i, req_i, n_done} = '0;
        rst_i = 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        reg_r(4'h0);
        check(rd_q, 16'hffff);
        reg_r(4'h5);
        check(rd_q, 16'h0000);
        reg_w(4'h0, 16'h5aa5);
        reg_r(4'h0);
        check(rd_q, 16'h5aa5);
        reg_w(4'h0, 16'ha55a);
        reg_w(4'h3, 16'h0000);
        reg_r(4'h0);
        check(rd_q, 16'ha55a);
        @(posedge mclk_i);
        manual_rst_i <= 1'b1;
        standby_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        manual_rst_i <= 1'b0;
        standby_i <= 1'b0;
        reg_r(4'h0);
        check(rd_q, 16'ha55a);
        // Stretch on area 0 only, no idles anywhere
        reg_w(4'h0, 16'h0001);
        run(2'h0, 1'b0, 2'h0, 1'b0, 1'b0);
        check({14'h0, lead, trail}, 16'h0003);
        run(2'h1, 1'b1, 2'h0, 1'b0, 1'b0);
        check({14'h0, lead, trail}, 16'h0000);
        // Idle codes 0,3,2,1 for areas 3..0; back-to-back bits only on areas 3 and 1
        reg_w(4'h0, 16'h39a0);
        run(2'h0, 1'b0, 2'h1, 1'b0, 1'b1);
        check({8'h0, gap}, 16'h0001);
        run(2'h3, 1'b0, 2'h2, 1'b0, 1'b1);
        check({8'h0, gap}, 16'h0000);
        run(2'h2, 1'b0, 2'h3, 1'b0, 1'b1);
        check({8'h0, gap}, 16'h0003);
        run(2'h2, 1'b0, 2'h2, 1'b1, 1'b1);
        check({8'h0, gap}, 16'h0003);
        run(2'h1, 1'b0, 2'h1, 1'b1, 1'b1);
        check({8'h0, gap}, 16'h0002);
        run(2'h3, 1'b0, 2'h3, 1'b0, 1'b1);
        check({8'h0, gap}, 16'h0001);
        run(2'h0, 1'b0, 2'h0, 1'b0, 1'b1);
        check({8'h0, gap}, 16'h0000);
        run(2'h1, 1'b1, 2'h2, 1'b0, 1'b1);
        check({8'h0, gap}, 16'h0000);
        check({8'h0, err}, 16'h0000);
        check({8'h0, n_done}, {8'h0, xfer});
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        reg_r(4'h0);
        check(rd_q, 16'hffff);
        stop_test();
    end
endmodule
`default_nettype wire
